// ### src/tasr_top.sv
/*
  tasr_top: 16-bit operational status register of the remote terminal with
  strap capture, lockable terminal address and mirrored ready/active status.
  assumes: all inputs synchronous to mclk; master_reset_n is the functional
  master reset pin; execution_start_ctl comes from the configuration register;
  low_status carries bits 5..0 from logic outside this block.
*/
`timescale 1ns/1ns
// Notes on behaviour
// - every status bit is active high
// - master reset release loads bits 15-8 from pins
// - master reset clears bits 7 to 3
// - bits 8 to 0 ignore all writes
// - unfrozen: writes need execution start low
// - frozen: bits 15 to 9 read-only
// - only sys_rst, or master reset with pin low, unfreezes
// - software reset leaves register untouched
// - address 15-11, parity 10, rewritable when allowed
// - writing bit 9 high freezes address
// - bit 8 holds sampled self-init pin
// - after self-init, wait for execution start
// - self-init may set execution start itself
// - bit 7 mirrors ready pin
module tasr_top #(
  parameter int ADDR_W      = 16,
  parameter int INIT_CYCLES = tasr_pkg::INIT_CYCLES
) (
  input  wire logic                          mclk,
  input  wire logic                          sys_rst,
  input  wire logic                          clk_en,
  input  wire logic                          master_reset_n,
  input  wire tasr_pkg::tasr_straps_s        strap_pins,
  input  wire logic                          soft_reset,
  input  wire logic                          execution_start_ctl,
  input  wire logic                          host_cs,
  input  wire logic                          host_we,
  input  wire logic [ADDR_W-1:0]             host_addr,
  input  wire logic [tasr_pkg::DATA_W-1:0]   host_wdata,
  input  wire logic                          init_wr,
  input  wire logic [tasr_pkg::DATA_W-1:0]   init_wdata,
  input  wire logic                          cmd_valid,
  input  wire logic                          cmd_done,
  input  wire logic [tasr_pkg::LOW_W-1:0]    low_status,
  output logic [tasr_pkg::DATA_W-1:0]        host_rdata,
  output logic                               host_rvalid,
  output logic                               ready_out,
  output logic                               active_out,
  output logic                               addr_frozen,
  output logic [4:0]                         active_terminal_addr
);

  logic                               mr_rise;
  logic                               ready_int;
  logic [7:0]                         upper_reg;
  logic [7:0]                         upper_next;
  logic                               active_reg;
  logic                               active_next;
  logic [tasr_pkg::DATA_W-1:0]        rdata_reg;
  logic [tasr_pkg::DATA_W-1:0]        rdata_next;
  logic                               rvalid_reg;
  logic                               rvalid_next;
  logic                               hit;
  logic                               wr_open;
  tasr_pkg::tasr_wr_s                 wr_req;
  logic [tasr_pkg::DATA_W-1:0]        opstat;
  logic [tasr_pkg::LOW_W-1:0]         low_view;

  tasr_edge_det u_mr_edge (
    .mclk    (mclk),
    .sys_rst (sys_rst),
    .clk_en  (clk_en),
    .level   (master_reset_n),
    .rise    (mr_rise)
  );

  tasr_init_timer #(
    .INIT_CYCLES (INIT_CYCLES)
  ) u_init_timer (
    .mclk           (mclk),
    .sys_rst        (sys_rst),
    .clk_en         (clk_en),
    .master_reset_n (master_reset_n),
    .rise           (mr_rise),
    .ready          (ready_int)
  );

  assign hit = host_cs && (host_addr == ADDR_W'(tasr_pkg::OPSTAT_OFFSET));

  // writes reach bits 15..9 only while unfrozen and execution stopped
  assign wr_open = !upper_reg[tasr_pkg::FREEZE_BIT - 8] && !execution_start_ctl;

  // self-init owns the register while it runs, so it wins a collision
  always_comb begin
    wr_req = '0;
    if (init_wr) begin
      wr_req.valid = 1'b1;
      wr_req.data  = init_wdata[tasr_pkg::WR_MSB:tasr_pkg::WR_LSB];
    end else if (hit && host_we) begin
      wr_req.valid = 1'b1;
      wr_req.data  = host_wdata[tasr_pkg::WR_MSB:tasr_pkg::WR_LSB];
    end
  end

  // soft_reset is deliberately not used here
  always_comb begin
    upper_next = upper_reg;
    if (clk_en) begin
      if (mr_rise) begin
        upper_next = strap_pins;
      end else if (wr_req.valid && wr_open) begin
        // bit 8 is kept; blocked writes fall through unchanged
        upper_next = {wr_req.data, upper_reg[0]};
      end
    end
  end

  // set wins over clear when both arrive together
  always_comb begin
    active_next = active_reg;
    if (clk_en) begin
      if (!master_reset_n) begin
        active_next = 1'b0;
      end else if (cmd_valid) begin
        active_next = 1'b1;
      end else if (cmd_done) begin
        active_next = 1'b0;
      end
    end
  end

  // bits 5..3 read zero while master reset is held
  assign low_view = master_reset_n ? low_status :
                    {{(tasr_pkg::CLR_MSB - tasr_pkg::CLR_LSB + 1){1'b0}},
                     low_status[tasr_pkg::CLR_LSB-1:0]};

  assign opstat = {upper_reg, ready_int, active_reg, low_view};

  always_comb begin
    rdata_next  = rdata_reg;
    rvalid_next = rvalid_reg;
    if (clk_en) begin
      rvalid_next = hit && !host_we;
      if (hit && !host_we) begin
        rdata_next = opstat;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      upper_reg  <= tasr_pkg::UPPER_RST;
      active_reg <= 1'b0;
      rdata_reg  <= tasr_pkg::RDATA_RST;
      rvalid_reg <= 1'b0;
    end else begin
      upper_reg  <= upper_next;
      active_reg <= active_next;
      rdata_reg  <= rdata_next;
      rvalid_reg <= rvalid_next;
    end
  end

  assign host_rdata  = rdata_reg;
  assign host_rvalid = rvalid_reg;
  assign ready_out   = ready_int;
  assign active_out  = active_reg;
  // operation starts only once execution_start_ctl is set, by host or self-init
  assign addr_frozen = upper_reg[tasr_pkg::FREEZE_BIT - 8];
  assign active_terminal_addr = upper_reg[tasr_pkg::ADDR_MSB - tasr_pkg::SELF_INIT_BIT:
                                          tasr_pkg::ADDR_LSB - tasr_pkg::SELF_INIT_BIT];

endmodule

// ### src/tasr_pkg.sv
/*
  tasr_pkg: constants, field layout and carrier types for the terminal
  address / operational status register.
  assumes: a single 100 MHz clock domain, one 16-bit register on the host port.
*/
package tasr_pkg;

  localparam int          DATA_W         = 16;
  localparam logic [15:0] OPSTAT_OFFSET  = 16'h0002;

  // field positions inside the status word
  localparam int          ADDR_MSB       = 15;
  localparam int          ADDR_LSB       = 11;
  localparam int          PARITY_BIT     = 10;
  localparam int          FREEZE_BIT     = 9;
  localparam int          SELF_INIT_BIT  = 8;
  localparam int          READY_BIT      = 7;
  localparam int          ACTIVE_BIT     = 6;
  localparam int          WR_MSB         = 15;
  localparam int          WR_LSB         = 9;
  localparam int          LOW_W          = 6;
  localparam int          CLR_MSB        = 5;
  localparam int          CLR_LSB        = 3;

  localparam logic [7:0]  UPPER_RST      = 8'h00;
  localparam logic [6:0]  WR_FIELD_RST   = 7'h00;
  localparam logic [15:0] RDATA_RST      = 16'h0000;

  // post-reset internal initialisation time before ready rises
  localparam int          CLK_PERIOD_NS  = 10;
  localparam int          INIT_TIME_NS   = 1000;
  localparam int          INIT_CYCLES    = (INIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          INIT_CNT_W     = 12;

  // strap pins, packed in the same order as register bits 15..8
  typedef struct packed {
    logic [4:0] terminal_addr;
    logic       terminal_addr_parity;
    logic       addr_freeze;
    logic       self_init_enable;
  } tasr_straps_s;

  // one write request into bits 15..9
  typedef struct packed {
    logic       valid;
    logic [6:0] data;
  } tasr_wr_s;

  typedef enum logic [1:0] {
    TASR_INIT_IDLE  = 2'b00,
    TASR_INIT_COUNT = 2'b01,
    TASR_INIT_DONE  = 2'b10
  } tasr_init_state_e;

endpackage

// ### src/tasr_edge_det.sv
/*
  tasr_edge_det: finds the rising edge of the active-low master reset input.
  assumes: the input is already synchronous to mclk.
*/
`timescale 1ns/1ns
module tasr_edge_det (
  input  wire logic mclk,
  input  wire logic sys_rst,
  input  wire logic clk_en,
  input  wire logic level,
  output logic      rise
);

  logic prev_reg;
  logic prev_next;

  // prev clears on sys_rst so a pin already high is seen as a release
  always_comb begin
    prev_next = clk_en ? level : prev_reg;
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      prev_reg <= 1'b0;
    end else begin
      prev_reg <= prev_next;
    end
  end

  assign rise = clk_en & level & ~prev_reg;

endmodule

// ### src/tasr_init_timer.sv
/*
  tasr_init_timer: post-reset internal initialisation timer driving ready.
  assumes: master_reset_n synchronous to mclk; rise is a one-cycle pulse.
*/
`timescale 1ns/1ns
module tasr_init_timer #(
  parameter int INIT_CYCLES = tasr_pkg::INIT_CYCLES
) (
  input  wire logic mclk,
  input  wire logic sys_rst,
  input  wire logic clk_en,
  input  wire logic master_reset_n,
  input  wire logic rise,
  output logic      ready
);

  tasr_pkg::tasr_init_state_e            state_reg;
  tasr_pkg::tasr_init_state_e            state_next;
  logic [tasr_pkg::INIT_CNT_W-1:0]       cnt_reg;
  logic [tasr_pkg::INIT_CNT_W-1:0]       cnt_next;

  localparam logic [tasr_pkg::INIT_CNT_W-1:0] CNT_LAST =
    tasr_pkg::INIT_CNT_W'(INIT_CYCLES - 1);

  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    if (clk_en) begin
      if (!master_reset_n) begin
        state_next = tasr_pkg::TASR_INIT_IDLE;
        cnt_next   = '0;
      end else begin
        case (state_reg)
          tasr_pkg::TASR_INIT_IDLE: begin
            if (rise) begin
              state_next = tasr_pkg::TASR_INIT_COUNT;
              cnt_next   = '0;
            end
          end
          tasr_pkg::TASR_INIT_COUNT: begin
            if (cnt_reg == CNT_LAST) begin
              state_next = tasr_pkg::TASR_INIT_DONE;
            end else begin
              cnt_next = cnt_reg + 1'b1;
            end
          end
          tasr_pkg::TASR_INIT_DONE: begin
            state_next = tasr_pkg::TASR_INIT_DONE;
          end
          default: begin
            state_next = tasr_pkg::TASR_INIT_IDLE;
          end
        endcase
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      state_reg <= tasr_pkg::TASR_INIT_IDLE;
      cnt_reg   <= '0;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
    end
  end

  assign ready = (state_reg == tasr_pkg::TASR_INIT_DONE);

endmodule

// ### testbench/tasr_host_model.sv
/* tasr_host_model: host processor on the register port of tasr_top.
   assumes: calls start just after a rising mclk edge; rdata read one cycle after taking. */
`timescale 1ns/1ns
module tasr_host_model (
  input  wire logic        mclk,
  input  wire logic        host_rvalid,
  input  wire logic [15:0] host_rdata,
  output logic             host_cs,
  output logic             host_we,
  output logic [15:0]      host_addr,
  output logic [15:0]      host_wdata
);
  initial begin
    host_cs = 1'b0;
    host_we = 1'b0;
    host_addr = 16'h0000;
    host_wdata = 16'h0000;
  end
  // released bus lines flip so stale data can never pass for fresh
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge mclk);
    host_cs <= 1'b1;
    host_we <= 1'b1;
    host_addr <= a;
    host_wdata <= d;
    @(posedge mclk);
    host_cs <= 1'b0;
    host_wdata <= ~d;
  endtask
  task automatic rd(input logic [15:0] a, output logic [15:0] d);
    @(posedge mclk);
    host_cs <= 1'b1;
    host_we <= 1'b0;
    host_addr <= a;
    @(posedge mclk);
    host_cs <= 1'b0;
    host_addr <= ~a;
    @(posedge mclk);
    d = host_rvalid ? host_rdata : 16'hxxxx;
  endtask
endmodule

// ### testbench/tasr_top_properties.sv
/* tasr_top_checker: assertions on the ports of tasr_top.
   assumes: one clock domain; clk_en drops only after ready is up. */
`timescale 1ns/1ns
module tasr_top_checker #(
  parameter int ADDR_W      = 16,
  parameter int INIT_CYCLES = 4
) (
  input wire logic              mclk,
  input wire logic              sys_rst,
  input wire logic              clk_en,
  input wire logic              master_reset_n,
  input wire logic [7:0]        strap_pins,
  input wire logic              execution_start_ctl,
  input wire logic              host_cs,
  input wire logic              host_we,
  input wire logic [ADDR_W-1:0] host_addr,
  input wire logic              cmd_valid,
  input wire logic              cmd_done,
  input wire logic [15:0]       host_rdata,
  input wire logic              host_rvalid,
  input wire logic              ready_out,
  input wire logic              active_out,
  input wire logic              addr_frozen,
  input wire logic [4:0]        active_terminal_addr
);
  logic       req;
  logic       live_reg;
  logic       live_next;
  logic [7:0] cnt_reg;
  logic [7:0] cnt_next;
  assign req = clk_en && host_cs && !host_we && host_addr == 16'h0002;
  // cycles since master reset went high; saturates so long runs stay quiet
  always_comb begin
    live_next = 1'b1;
    cnt_next = cnt_reg;
    if (!master_reset_n) cnt_next = 8'h00;
    else if (cnt_reg != 8'hff) cnt_next = cnt_reg + 8'h01;
  end
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      live_reg <= 1'b0;
      cnt_reg <= 8'h00;
    end else begin
      live_reg <= live_next;
      cnt_reg <= cnt_next;
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  property p_rd_answer; req |=> host_rvalid; endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
  property p_rd_only; host_rvalid |-> $past(req); endproperty
  a_rd_only: assert property (p_rd_only) else $error("answer without read");
  property p_rd_word; host_rvalid |-> host_rdata[15:11] == $past(active_terminal_addr)
    && host_rdata[9] == $past(addr_frozen) && host_rdata[7:6] == $past({ready_out, active_out});
  endproperty
  a_rd_word: assert property (p_rd_word) else $error("read word differs");
  property p_strap_load; master_reset_n && !$past(master_reset_n) |=>
    active_terminal_addr == $past(strap_pins[7:3]) && addr_frozen == $past(strap_pins[1]);
  endproperty
  a_strap_load: assert property (p_strap_load) else $error("straps not loaded");
  property p_frozen; live_reg && addr_frozen && master_reset_n && $past(master_reset_n) |=>
    addr_frozen && $stable(active_terminal_addr); endproperty
  a_frozen: assert property (p_frozen) else $error("frozen address moved");
  property p_exec_block; live_reg && execution_start_ctl && master_reset_n
    && $past(master_reset_n) |=> $stable(active_terminal_addr) && $stable(addr_frozen);
  endproperty
  a_exec_block: assert property (p_exec_block) else $error("write while running");
  property p_mr_clear; !master_reset_n |=> !ready_out && !active_out; endproperty
  a_mr_clear: assert property (p_mr_clear) else $error("status not cleared");
  property p_ready_time; $rose(ready_out) |-> cnt_reg == INIT_CYCLES + 1; endproperty
  a_ready_time: assert property (p_ready_time) else $error("ready at wrong time");
  property p_act_set; clk_en && cmd_valid && master_reset_n |=> active_out; endproperty
  a_act_set: assert property (p_act_set) else $error("active not set");
  property p_act_clr; cmd_done && !cmd_valid && master_reset_n |=> !active_out; endproperty
  a_act_clr: assert property (p_act_clr) else $error("active not cleared");
endmodule
bind tasr_top tasr_top_checker #(.ADDR_W(ADDR_W), .INIT_CYCLES(INIT_CYCLES)) tasr_top_checker_i (
  .mclk, .sys_rst, .clk_en, .master_reset_n, .strap_pins, .execution_start_ctl, .host_cs,
  .host_we, .host_addr, .cmd_valid, .cmd_done, .host_rdata, .host_rvalid, .ready_out,
  .active_out, .addr_frozen, .active_terminal_addr);

// ### testbench/tasr_bench.sv
/* tasr_bench: self-checking bench for tasr_top with a host model.
   assumes: tasr_pkg compiled first; short init count of 4 cycles. */
`timescale 1ns/1ns
module tasr_bench;
  logic mclk = 1'b0, sys_rst = 1'b1, master_reset_n = 1'b0, soft_reset = 1'b0, clk_en = 1'b1;
  logic execution_start_ctl = 1'b0, init_wr = 1'b0, cmd_valid = 1'b0, cmd_done = 1'b0;
  logic host_cs, host_we, host_rvalid, ready_out, active_out, addr_frozen;
  logic [15:0] init_wdata = 16'h0000, host_addr, host_wdata, host_rdata, rd_v;
  logic [4:0]  active_terminal_addr;
  logic [7:0]  up = 8'h00;
  tasr_pkg::tasr_straps_s strap_pins = 8'h00;
  int n_mismatch = 0;
  int samples_checked = 0;
  tasr_top #(.INIT_CYCLES(4)) tasr_top_i (.mclk, .sys_rst, .clk_en, .master_reset_n,
    .strap_pins, .soft_reset, .execution_start_ctl, .host_cs, .host_we, .host_addr,
    .host_wdata, .init_wr, .init_wdata, .cmd_valid, .cmd_done, .low_status(6'h2b),
    .host_rdata, .host_rvalid, .ready_out, .active_out, .addr_frozen, .active_terminal_addr);
  tasr_host_model tasr_host_model_i (.mclk, .host_rvalid, .host_rdata, .host_cs, .host_we,
    .host_addr, .host_wdata);
  initial forever #5 mclk = ~mclk;
  task automatic results;
    $display("mismatches %0d comparisons %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic rdchk(input logic [7:0] lo);
    tasr_host_model_i.rd(16'h0002, rd_v);
    check(rd_v, {up, lo});
  endtask
  // low pulse with new straps; bits 5..3 read zero while held low
  task automatic mreset(input logic [7:0] s);
    @(posedge mclk);
    master_reset_n <= 1'b0;
    strap_pins <= s;
    rdchk(8'h03);
    master_reset_n <= 1'b1;
    up = s;
    for (int i = 0; i < 20 && ready_out !== 1'b1; i++) @(posedge mclk);
    if (ready_out !== 1'b1) begin
      n_mismatch++;
      results;
    end
    rdchk(8'hab);
  endtask
  task automatic t_write;
    tasr_host_model_i.wr(16'h0002, 16'h4cff);
    up = {7'h26, up[0]};
    rdchk(8'hab);
    execution_start_ctl <= 1'b1;
    tasr_host_model_i.wr(16'h0002, 16'h8200);
    execution_start_ctl <= 1'b0;
    rdchk(8'hab);
    tasr_host_model_i.wr(16'h0004, 16'h8200);
    @(posedge mclk) soft_reset <= 1'b1;
    @(posedge mclk) soft_reset <= 1'b0;
    rdchk(8'hab);
  endtask
  task automatic t_active;
    @(posedge mclk) cmd_valid <= 1'b1;
    @(posedge mclk) cmd_valid <= 1'b0;
    rdchk(8'heb);
    @(posedge mclk) cmd_done <= 1'b1;
    @(posedge mclk) cmd_done <= 1'b0;
    rdchk(8'hab);
    // a command seen while the clock enable is low must leave the status frozen
    @(posedge mclk) clk_en <= 1'b0;
    @(posedge mclk) cmd_valid <= 1'b1;
    @(posedge mclk) cmd_valid <= 1'b0;
    clk_en <= 1'b1;
    rdchk(8'hab);
    // left set on purpose so the next master reset has to clear it
    @(posedge mclk) cmd_valid <= 1'b1;
    @(posedge mclk) cmd_valid <= 1'b0;
  endtask
  task automatic t_freeze;
    @(posedge mclk) init_wr <= 1'b1;
    init_wdata <= 16'h9600;
    @(posedge mclk) init_wr <= 1'b0;
    up = {7'h4b, up[0]};
    rdchk(8'heb);
    tasr_host_model_i.wr(16'h0002, 16'h0000);
    rdchk(8'heb);
    mreset(8'hb7);
    tasr_host_model_i.wr(16'h0002, 16'h0000);
    rdchk(8'hab);
    mreset(8'hb5);
    tasr_host_model_i.wr(16'h0002, 16'h4c00);
    up = 8'h4d;
    rdchk(8'hab);
  endtask
  initial begin
    repeat (12) @(posedge mclk);
    sys_rst <= 1'b0;
    rdchk(8'h03);
    mreset(8'hb5);
    t_write;
    t_active;
    t_freeze;
    results;
  end
endmodule
